// ==== hw/eoc_div8.sv ====
// Divider that turns synchronized external clock edges into one-cycle peripheral ticks.
`timescale 1ns/100ps
module eoc_div8
  import eoc_pkg::*;
#(
  parameter int unsigned DIV = EOC_EXT_DIV
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic edge_i,
  input wire logic half_i,
  input wire logic clr_i,
  output logic tick_o
);

  // Room for the doubled count used by the divide-by-two modes.
  localparam int unsigned CW = $clog2(2 * DIV);
  localparam logic [CW-1:0] LAST_FULL = CW'(DIV - 1);
  localparam logic [CW-1:0] LAST_HALF = CW'(2 * DIV - 1);

  // The counter logic assumes a power of two of at least two.
  if (DIV < 2 || (DIV & (DIV - 1)) != 0) begin : g_bad_div
    $error("eoc_div8: DIV must be a power of two, at least 2");
  end

  logic [CW-1:0] cnt_q; // Counts external edges.
  logic tick_q; // Registered tick.
  wire logic [CW-1:0] last_w = half_i ? LAST_HALF : LAST_FULL;
  wire logic wrap_w = edge_i && (cnt_q >= last_w);

  // Count one step per external edge; a tick leaves on the wrapping edge.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (clr_i) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= wrap_w;
      if (wrap_w) begin
        cnt_q <= '0;
      end else if (edge_i) begin
        cnt_q <= cnt_q + CW'(1);
      end
    end
  end

  assign tick_o = tick_q;

endmodule

// ==== hw/eoc_pkg.sv ====
// Package with register map, field layout, mode codes and carrier types of the oscillator control.
package eoc_pkg;

  // Avalon-MM byte address width of the register window.
  localparam int unsigned EOC_AW = 4;

  // Register byte offsets, one aligned 32-bit word each.
  localparam logic [EOC_AW-1:0] EOC_CTRL_OFS = 4'h0;
  localparam logic [EOC_AW-1:0] EOC_CLKSEL_OFS = 4'h4;
  localparam logic [EOC_AW-1:0] EOC_PERSEL_OFS = 4'h8;
  localparam logic [EOC_AW-1:0] EOC_STAT_OFS = 4'hc;

  // Field positions inside the oscillator control register.
  localparam int unsigned EOC_VALID_BIT = 7;
  localparam int unsigned EOC_MODE_LSB = 4;
  localparam int unsigned EOC_RANGE_LSB = 0;

  // Field positions of the clock select and peripheral select registers.
  localparam int unsigned EOC_CLKSEL_EXT_BIT = 0;
  localparam int unsigned EOC_PERSEL_TMR_BIT = 0;
  localparam int unsigned EOC_PERSEL_CA_BIT = 1;

  // Reset values.
  localparam logic [2:0] EOC_MODE_RST = 3'h0;
  localparam logic [2:0] EOC_RANGE_RST = 3'h0;

  // Default division of the external clock fed to the timers and counter array.
  localparam int unsigned EOC_EXT_DIV = 8;

  // Oscillator mode field encodings.
  typedef enum logic [2:0] {
    EOC_MODE_OFF0 = 3'h0,
    EOC_MODE_OFF1 = 3'h1,
    EOC_MODE_CMOS = 3'h2,
    EOC_MODE_CMOS2 = 3'h3,
    EOC_MODE_RC = 3'h4,
    EOC_MODE_CAP = 3'h5,
    EOC_MODE_XTAL = 3'h6,
    EOC_MODE_OSC_OUTPUT_PIN = 3'h7
  } eoc_mode_t;

  // Settings handed to the analog drive circuit.
  typedef struct packed {
    logic [2:0] mode;
    logic [2:0] range;
  } eoc_ctrl_t;

  // Port pins claimed by the oscillator.
  typedef struct packed {
    logic p02_claim;
    logic p03_claim;
  } eoc_pins_t;

  // System clock source switching states, Gray along INT-WAIT-EXT-BACK.
  typedef enum logic [1:0] {
    EOC_SRC_INT = 2'h0,
    EOC_SRC_WAIT = 2'h1,
    EOC_SRC_EXT = 2'h3,
    EOC_SRC_BACK = 2'h2
  } eoc_src_t;

endpackage

// ==== hw/eoc_top.sv ====
// Top of the external oscillator control: registers, mode decode, pin claims, clock switch.
`timescale 1ns/100ps
// How it works
// - External clock divided by eight, or sixteen in modes 3 and 7, feeds timers.
// - Divided clock synchronized, jitter one system clock cycle.
// - Crystal mode claims both oscillator pins.
// - Other running modes claim only output pin.
// - Higher range in RC trades current.
// - Decode three-bit oscillator mode field.
module eoc_top
  import eoc_pkg::*;
#(
  parameter int unsigned EXT_DIV = EOC_EXT_DIV
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [EOC_AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic ext_osc_clk_i,
  input wire logic osc_amp_ok_i,
  output logic osc_enable_o,
  output eoc_ctrl_t osc_ctrl_o,
  output eoc_pins_t pins_o,
  output logic system_clock_out_ext_sel_o,
  output logic timer_ext_tick_o,
  output logic ca_ext_tick_o
);

  // Register state.
  eoc_ctrl_t ctrl_q; // Mode and frequency range fields.
  logic clk_req_q; // Software request to run the system clock from outside.
  logic [1:0] persel_q; // Peripheral clock select, timers and counter array.
  logic wait_q; // Waitrequest, high while no answer is ready.
  logic [31:0] rdata_q; // Read data, valid with waitrequest low.

  // Synchronisers for the asynchronous pins.
  logic ext_m_q; // First stage of the external clock, read only by ext_s_q.
  logic ext_s_q; // Second stage of the external clock.
  logic ext_d_q; // Delayed copy for edge detection.
  logic amp_m_q; // First stage of the amplitude detector.
  logic amp_s_q; // Second stage of the amplitude detector.

  // Output and switching state.
  eoc_src_t src_q;
  eoc_src_t src_d;
  logic sel_q; // System clock source, one means external.
  eoc_ctrl_t ctrl_out_q; // Registered copy for the analog circuit.
  eoc_pins_t pins_q; // Registered pin claims.
  logic en_q; // Registered drive enable.
  logic timer_tick_q;
  logic ca_tick_q;

  // Bus decode.
  wire logic req_w = avs_read_i || avs_write_i;
  wire logic done_w = req_w && !wait_q;
  wire logic wr_w = avs_write_i && !wait_q && avs_byteenable_i[0];
  wire logic hit_ctrl_w = (avs_address_i == EOC_CTRL_OFS);
  wire logic hit_clksel_w = (avs_address_i == EOC_CLKSEL_OFS);
  wire logic hit_persel_w = (avs_address_i == EOC_PERSEL_OFS);
  wire logic hit_stat_w = (avs_address_i == EOC_STAT_OFS);

  // Mode decode: 00x is off, 01x CMOS, 100 RC, 101 capacitor, 11x crystal.
  wire eoc_mode_t mode_w = eoc_mode_t'(ctrl_q.mode);
  wire logic mode_on_w = (mode_w != EOC_MODE_OFF0) && (mode_w != EOC_MODE_OFF1);
  wire logic mode_xtal_w = (mode_w == EOC_MODE_XTAL) || (mode_w == EOC_MODE_OSC_OUTPUT_PIN);
  wire logic mode_half_w = (mode_w == EOC_MODE_CMOS2) || (mode_w == EOC_MODE_OSC_OUTPUT_PIN);

  // The valid flag means something only while a crystal is being driven.
  wire logic valid_w = mode_xtal_w && amp_s_q;

  // The external source is usable once running, and for a crystal once stable.
  wire logic ext_ready_w = mode_on_w && (!mode_xtal_w || valid_w);
  wire logic ext_rise_w = ext_s_q && !ext_d_q;

  // Read data mux; unmapped addresses read as zero.
  wire logic [7:0] ctrl_rd_w = {valid_w, ctrl_q.mode, 1'b0, ctrl_q.range};
  wire logic [31:0] rd_mux_w =
    hit_ctrl_w ? {24'h000000, ctrl_rd_w} :
    hit_clksel_w ? {31'h0, clk_req_q} :
    hit_persel_w ? {30'h0, persel_q} :
    hit_stat_w ? {28'h0000000, pins_q.p02_claim, pins_q.p03_claim, ext_ready_w, sel_q} :
    32'h00000000;

  // Each request gets one wait cycle, then completes at the next edge.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      wait_q <= !(req_w && wait_q);
      rdata_q <= rd_mux_w;
    end
  end

  // Register writes take effect at the edge that completes the request.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_q <= '{mode: EOC_MODE_RST, range: EOC_RANGE_RST};
      clk_req_q <= 1'b0;
      persel_q <= 2'h0;
    end else if (wr_w && done_w) begin
      if (hit_ctrl_w) begin
        ctrl_q.mode <= avs_writedata_i[EOC_MODE_LSB +: 3];
        ctrl_q.range <= avs_writedata_i[EOC_RANGE_LSB +: 3];
      end
      if (hit_clksel_w) begin
        clk_req_q <= avs_writedata_i[EOC_CLKSEL_EXT_BIT];
      end
      if (hit_persel_w) begin
        persel_q <= {avs_writedata_i[EOC_PERSEL_CA_BIT], avs_writedata_i[EOC_PERSEL_TMR_BIT]};
      end
    end
  end

  // Two flip-flops on each pin before any logic looks at it.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ext_m_q <= 1'b0;
      ext_s_q <= 1'b0;
      ext_d_q <= 1'b0;
      amp_m_q <= 1'b0;
      amp_s_q <= 1'b0;
    end else begin
      ext_m_q <= ext_osc_clk_i;
      ext_s_q <= ext_m_q;
      ext_d_q <= ext_s_q;
      amp_m_q <= osc_amp_ok_i;
      amp_s_q <= amp_m_q;
    end
  end

  // Source switch: apart from a loss of readiness in BACK, the select moves only while the synced
  // external clock is low, so a running source is not cut in the middle of a high phase.
  always_comb begin
    src_d = src_q;
    case (src_q)
      EOC_SRC_INT: begin
        if (clk_req_q && ext_ready_w) begin
          src_d = EOC_SRC_WAIT;
        end
      end
      EOC_SRC_WAIT: begin
        if (!clk_req_q || !ext_ready_w) begin
          src_d = EOC_SRC_INT;
        end else if (!ext_s_q) begin
          src_d = EOC_SRC_EXT;
        end
      end
      EOC_SRC_EXT: begin
        if (!clk_req_q || !ext_ready_w) begin
          src_d = EOC_SRC_BACK;
        end
      end
      EOC_SRC_BACK: begin
        // A dead source may sit high forever, so loss of readiness also ends the wait.
        if (!ext_s_q || !ext_ready_w) begin
          src_d = EOC_SRC_INT;
        end
      end
      default: begin
        src_d = EOC_SRC_INT;
      end
    endcase
  end

  // State register and the select derived from the next state.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      src_q <= EOC_SRC_INT;
      sel_q <= 1'b0;
    end else begin
      src_q <= src_d;
      sel_q <= (src_d == EOC_SRC_EXT) || (src_d == EOC_SRC_BACK);
    end
  end

  // Analog settings and pin claims; the range goes straight to the drive bias.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      en_q <= 1'b0;
      ctrl_out_q <= '{mode: EOC_MODE_RST, range: EOC_RANGE_RST};
      pins_q <= '{p02_claim: 1'b0, p03_claim: 1'b0};
    end else begin
      en_q <= mode_on_w;
      ctrl_out_q <= ctrl_q;
      pins_q.p02_claim <= mode_xtal_w;
      pins_q.p03_claim <= mode_on_w;
    end
  end

  // Dividers for the two peripheral consumers; cleared while not selected or off.
  logic tmr_div_tick_w;
  logic ca_div_tick_w;

  eoc_div8 #(
    .DIV(EXT_DIV)
  ) u_div_tmr (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .edge_i(ext_rise_w),
    .half_i(mode_half_w),
    .clr_i(!(mode_on_w && persel_q[EOC_PERSEL_TMR_BIT])),
    .tick_o(tmr_div_tick_w)
  );

  eoc_div8 #(
    .DIV(EXT_DIV)
  ) u_div_ca (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .edge_i(ext_rise_w),
    .half_i(mode_half_w),
    .clr_i(!(mode_on_w && persel_q[EOC_PERSEL_CA_BIT])),
    .tick_o(ca_div_tick_w)
  );

  // Ticks are re-registered so every output leaves a flip-flop of this module.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      timer_tick_q <= 1'b0;
      ca_tick_q <= 1'b0;
    end else begin
      timer_tick_q <= tmr_div_tick_w;
      ca_tick_q <= ca_div_tick_w;
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign osc_enable_o = en_q;
  assign osc_ctrl_o = ctrl_out_q;
  assign pins_o = pins_q;
  assign system_clock_out_ext_sel_o = sel_q;
  assign timer_ext_tick_o = timer_tick_q;
  assign ca_ext_tick_o = ca_tick_q;

endmodule

// ==== tb/eoc_osc_model.sv ====
// Behavioural external oscillator that drives the clock pin and amplitude detector.
`timescale 1ns/100ps
module eoc_osc_model
  import eoc_pkg::*;
#(
  parameter int unsigned SETTLE = 40
) (
  input wire logic en_i,
  input wire eoc_ctrl_t ctrl_i,
  output logic clk_o,
  output logic amp_ok_o
);
  // Crystal drive is on only in the two crystal modes.
  wire xt_w = en_i && ctrl_i.mode[2:1] == 2'h3;
  int unsigned cnt_q;
  initial clk_o = 1'b0;
  initial amp_ok_o = 1'b0;
  // Runs below the system clock rate and parks low while the drive is off.
  always #47 clk_o = en_i ? ~clk_o : 1'b0;
  // Amplitude needs real cycles, so a crystal is never valid at once.
  always @(posedge clk_o or negedge xt_w) begin
    if (!xt_w) begin
      cnt_q <= 0;
      amp_ok_o <= 1'b0;
    end else if (cnt_q < SETTLE) begin
      cnt_q <= cnt_q + 1;
    end else begin
      amp_ok_o <= 1'b1;
    end
  end
endmodule

// ==== tb/eoc_top_asserts.sv ====
// Concurrent checks on the oscillator control top ports.
`timescale 1ns/100ps
module eoc_top_asserts
  import eoc_pkg::*;
#(
  parameter int unsigned EXT_DIV = EOC_EXT_DIV
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic osc_amp_ok_i,
  input wire logic osc_enable_o,
  input wire eoc_ctrl_t osc_ctrl_o,
  input wire eoc_pins_t pins_o,
  input wire logic system_clock_out_ext_sel_o,
  input wire logic timer_ext_tick_o,
  input wire logic ca_ext_tick_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // Crystal modes are the codes whose top two mode bits are set.
  wire xtal_w = osc_ctrl_o.mode[2:1] == 2'h3;
  // A completed write, as seen at its completion edge.
  wire wdone_w = avs_write_i && !avs_waitrequest_o;
  bus_answer_a: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus request not answered after one wait cycle");
  answer_once_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("answer held longer than one cycle");
  upper_zero_a: assert property (
    !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  ctrl_write_a: assert property (
    !$stable(osc_ctrl_o) |-> $past(wdone_w) || $past(wdone_w, 2))
    else $error("oscillator settings changed without a write");
  enable_decode_a: assert property (
    osc_enable_o == (osc_ctrl_o.mode[2:1] != 2'h0))
    else $error("drive enable does not match mode");
  p02_claim_a: assert property (pins_o.p02_claim == xtal_w)
    else $error("input pin claim does not match crystal mode");
  p03_claim_a: assert property (pins_o.p03_claim == osc_enable_o)
    else $error("output pin claim does not match enable");
  tick_pulse_a: assert property (
    $rose(timer_ext_tick_o) |=> !timer_ext_tick_o [*7])
    else $error("timer tick spacing below eight edges");
  ca_pulse_a: assert property (
    $rose(ca_ext_tick_o) |=> !ca_ext_tick_o [*7])
    else $error("counter array tick spacing below eight edges");
  xtal_switch_a: assert property (
    $rose(system_clock_out_ext_sel_o) && xtal_w |-> $past(osc_amp_ok_i, 3))
    else $error("switched to crystal before it was stable");
endmodule
bind eoc_top eoc_top_asserts #(.EXT_DIV(EXT_DIV)) asrt_u (.clk_i(clk_i),
  .arst_n_i(arst_n_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .osc_amp_ok_i(osc_amp_ok_i), .osc_enable_o(osc_enable_o), .osc_ctrl_o(osc_ctrl_o),
  .pins_o(pins_o), .system_clock_out_ext_sel_o(system_clock_out_ext_sel_o),
  .timer_ext_tick_o(timer_ext_tick_o), .ca_ext_tick_o(ca_ext_tick_o));

// ==== tb/tb_top.sv ====
// Self-checking bench for the oscillator control block.
`timescale 1ns/100ps
module tb_top
  import eoc_pkg::*;
;
  logic clk_i = 1'b0;
  logic arst_n = 1'b0;
  logic rd = 1'b0, wr = 1'b0;
  logic [EOC_AW-1:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, rdata, q;
  logic [3:0] be = 4'hf;
  logic wreq, ext, amp, en, sel, tt, ct;
  eoc_ctrl_t ctrl;
  eoc_pins_t pins;
  int err_total = 0, n_compared = 0, tcnt, ccnt, ecnt, n;
  // Expected {enable, input pin claim, output pin claim} per mode code.
  logic [2:0] exp_r [8] = '{3'h0, 3'h0, 3'h5, 3'h5, 3'h5, 3'h5, 3'h7, 3'h7};
  always #12.5 clk_i = ~clk_i;
  eoc_top dut_u (.clk_i(clk_i), .arst_n_i(arst_n), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .ext_osc_clk_i(ext),
    .osc_amp_ok_i(amp), .osc_enable_o(en), .osc_ctrl_o(ctrl), .pins_o(pins),
    .system_clock_out_ext_sel_o(sel), .timer_ext_tick_o(tt), .ca_ext_tick_o(ct));
  eoc_osc_model osc_u (.en_i(en), .ctrl_i(ctrl), .clk_o(ext), .amp_ok_o(amp));
  // Tick and edge counters for the divided clock windows.
  always @(posedge clk_i) begin
    if (tt === 1'b1) tcnt++;
    if (ct === 1'b1) ccnt++;
  end
  always @(posedge ext) ecnt++;
  task automatic close_out;
    if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      err_total++;
    end
  endtask
  // One bus cycle; the request holds until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [EOC_AW-1:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    wr <= w; rd <= !w; adr <= a; wd <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (wreq !== 1'b0 && k < 100);
    // A request that never completes counts as a mismatch.
    if (wreq !== 1'b0) chk(wreq, 1'b0);
    q = rdata;
    wr <= 1'b0; rd <= 1'b0;
  endtask
  // Counts ticks over 80 external edges; phase allows one either way.
  // Eight idle cycles first, so a tick still in the pipeline is not counted.
  task automatic ticks(input int lo, input int hi, input int clo, input int chi);
    repeat (8) @(posedge clk_i);
    n = 0; tcnt = 0; ccnt = 0; ecnt = 0;
    while (ecnt < 80 && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    chk(ecnt >= 80, 1);
    chk(tcnt >= lo && tcnt <= hi, 1);
    chk(ccnt >= clo && ccnt <= chi, 1);
  endtask
  initial begin
    #2000000;
    chk(32'h0, 32'h1);
    close_out();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    arst_n <= 1'b1;
    for (int m = 0; m < 8; m++) begin
      bus(1'b1, EOC_CTRL_OFS, {25'h0, m[2:0], 1'b0, m[2:0]});
      bus(1'b0, EOC_CTRL_OFS, 32'h0);
      chk(q & 32'hffffff7f, {25'h0, m[2:0], 1'b0, m[2:0]});
      chk({en, pins}, {29'h0, exp_r[m]});
      chk(ctrl, {26'h0, m[2:0], m[2:0]});
    end
    // Drive off first, pins parked low and analog before the crystal starts.
    bus(1'b1, EOC_CTRL_OFS, 32'h0);
    bus(1'b1, EOC_CTRL_OFS, 32'h67);
    bus(1'b0, EOC_CTRL_OFS, 32'h0);
    chk(q, 32'h67);
    n = 0;
    do begin
      bus(1'b0, EOC_CTRL_OFS, 32'h0);
      n++;
    end while (q[7] !== 1'b1 && n < 200);
    chk(q, 32'he7);
    bus(1'b1, EOC_CLKSEL_OFS, 32'h1);
    for (n = 0; sel !== 1'b1 && n < 50; n++) @(posedge clk_i);
    chk(sel, 1);
    bus(1'b0, EOC_STAT_OFS, 32'h0);
    chk(q & 32'hd, 32'hd);
    bus(1'b1, EOC_CLKSEL_OFS, 32'h0);
    for (n = 0; sel !== 1'b0 && n < 50; n++) @(posedge clk_i);
    chk(sel, 0);
    bus(1'b1, EOC_CTRL_OFS, 32'h20);
    ticks(0, 0, 0, 0);
    bus(1'b1, EOC_PERSEL_OFS, 32'h3);
    ticks(9, 11, 9, 11);
    bus(1'b1, EOC_PERSEL_OFS, 32'h1);
    ticks(9, 11, 0, 0);
    bus(1'b1, EOC_CTRL_OFS, 32'h30);
    ticks(4, 6, 0, 0);
    be <= 4'he;
    bus(1'b1, EOC_CTRL_OFS, 32'h44);
    be <= 4'hf;
    bus(1'b1, 4'h2, 32'hff);
    bus(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, EOC_CTRL_OFS, 32'h0);
    chk(q, 32'h30);
    arst_n <= 1'b0;
    @(posedge clk_i);
    #1;
    chk({wreq, en, pins, sel, tt, ct, ctrl}, 32'h1000);
    chk(rdata, 32'h0);
    @(posedge clk_i);
    arst_n <= 1'b1;
    bus(1'b0, EOC_CTRL_OFS, 32'h0);
    chk(q, 32'h0);
    close_out();
  end
endmodule
